// >>> pal_pkg.sv
// Purpose: Constants for the page attribute lookup block
// Assumes: 100 MHz core clock, single domain
// Notes: Memory type codes and table reset image live here
package pal_pkg;
  localparam logic [31:0] PAL_TABLE_ADDR = 32'h0000_0277;
  localparam logic [31:0] PAL_QUERY_LEAF = 32'h0000_0001;
  localparam int PAL_QUERY_BIT = 16;
  localparam int PAL_ENTRIES = 8;
  localparam int PAL_ENTRY_W = 8;
  localparam int PAL_TYPE_W = 3;
  localparam int PAL_PTE_ATTR_BIT = 7;
  localparam int PAL_PDE_ATTR_BIT = 12;
  localparam int PAL_CD_BIT = 4;
  localparam int PAL_WRITE_THROUGH_BIT = 3;
  localparam logic [2:0] PAL_UNCACHEABLE = 3'h0;
  localparam logic [2:0] PAL_WRITE_COMBINING = 3'h1;
  localparam logic [2:0] PAL_WRITE_THROUGH_TYPE = 3'h4;
  localparam logic [2:0] PAL_WRITE_PROTECTED = 3'h5;
  localparam logic [2:0] PAL_WRITE_BACK = 3'h6;
  localparam logic [2:0] PAL_WEAK_UNCACHEABLE = 3'h7;
  localparam logic [63:0] PAL_TABLE_RESET = 64'h0007_0406_0007_0406;
endpackage : pal_pkg

// >>> pal_lookup.sv
// Purpose: Page memory-type attribute table with fault checks and lookup
// Assumes: Requests are one-cycle strobes synchronous to clk
// Notes: Effective type merges table type with the range-register type
//
// Overview of operation
// - Feature query leaf 1 reports bit 16
// - Lookup always active, no enable control
// - Table lives at fixed register address 277H
// - Eight byte entries, low three bits type
// - Six legal type encodings, rest reserved
// - Reserved type write faults and is rejected
// - Index is attribute, cache-disable, write-through bits
// - Attribute bit 7 small, 12 large pages
// - Cache-disable bit 4, write-through bit 3
// - Combine table type with range-register type
// - Hard reset loads four default types, twice
// - Soft init reset keeps the table
// - Access only by privilege level zero
// - Entry bits never choose type directly
`timescale 1ns/100ps
`default_nettype none
module pal_lookup
  import pal_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_init,
  input wire logic query_valid,
  input wire logic [31:0] query_leaf,
  output logic [31:0] query_result_r,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic [1:0] privilege_level,
  output logic [63:0] reg_rdata_r,
  output logic reg_done_r,
  output logic protection_fault_r,
  input wire logic lookup_valid,
  input wire logic large_page,
  input wire logic [63:0] page_entry,
  input wire logic [2:0] range_type,
  output logic lookup_done_r,
  output logic [2:0] table_type_r,
  output logic [2:0] effective_type_r
);
  logic [63:0] page_attribute_table_r;
  logic [PAL_ENTRIES-1:0] entry_bad;
  logic hit;
  logic priv_ok;
  logic wr_bad;
  logic attribute_index_high_bit;
  logic cache_disable_bit;
  logic write_through_bit;
  logic [2:0] index;
  logic [2:0] sel_type;
  logic [2:0] eff_type;

  // Per-entry legality; 02H, 03H and any upper bit are refused
  genvar g;
  generate
    for (g = 0; g < PAL_ENTRIES; g++) begin : g_chk
      assign entry_bad[g] =
        (|reg_wdata[g*PAL_ENTRY_W+PAL_TYPE_W +: 5]) ||
        (reg_wdata[g*PAL_ENTRY_W +: PAL_TYPE_W] == 3'h2) ||
        (reg_wdata[g*PAL_ENTRY_W +: PAL_TYPE_W] == 3'h3);
    end
  endgenerate

  assign hit = (reg_addr == PAL_TABLE_ADDR);
  assign priv_ok = (privilege_level == 2'h0);
  assign wr_bad = |entry_bad;

  // Attribute bit position depends on page size
  assign attribute_index_high_bit = large_page ?
    page_entry[PAL_PDE_ATTR_BIT] : page_entry[PAL_PTE_ATTR_BIT];
  assign cache_disable_bit = page_entry[PAL_CD_BIT];
  assign write_through_bit = page_entry[PAL_WRITE_THROUGH_BIT];
  assign index = {attribute_index_high_bit, cache_disable_bit,
                  write_through_bit};
  // Always through the table, never the raw bits
  assign sel_type = page_attribute_table_r[index*PAL_ENTRY_W +: PAL_TYPE_W];

  // Simplified merge: uncacheable range wins, write-combining range replaces write-back and keeps any other table type,
  // write-through range downgrades write-back, weak-uncacheable table type becomes uncacheable, otherwise table type
  always_comb begin
    if (range_type == PAL_UNCACHEABLE) begin
      eff_type = PAL_UNCACHEABLE;
    end else if (range_type == PAL_WRITE_COMBINING) begin
      eff_type = (sel_type == PAL_WRITE_BACK) ?
        PAL_WRITE_COMBINING : sel_type;
    end else if (range_type == PAL_WRITE_THROUGH_TYPE &&
                 sel_type == PAL_WRITE_BACK) begin
      eff_type = PAL_WRITE_THROUGH_TYPE;
    end else if (sel_type == PAL_WEAK_UNCACHEABLE) begin
      eff_type = PAL_UNCACHEABLE;
    end else begin
      eff_type = sel_type;
    end
  end

  // Table storage; soft init deliberately leaves it alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_attribute_table_r <= PAL_TABLE_RESET;
    end else if (reg_write && hit && priv_ok && !wr_bad && !soft_init) begin
      page_attribute_table_r <= reg_wdata;
    end
  end

  // Register access answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_done_r <= 1'b0;
      protection_fault_r <= 1'b0;
      reg_rdata_r <= 64'h0;
    end else begin
      reg_done_r <= (reg_read || reg_write) && !soft_init;
      protection_fault_r <= !soft_init && (reg_read || reg_write) &&
        (!hit || !priv_ok || (reg_write && wr_bad));
      if (reg_read && hit && priv_ok && !soft_init) begin
        reg_rdata_r <= page_attribute_table_r;
      end else begin
        reg_rdata_r <= 64'h0;
      end
    end
  end

  // Feature query
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      query_result_r <= 32'h0;
    end else if (query_valid) begin
      query_result_r <= 32'h0;
      query_result_r[PAL_QUERY_BIT] <= (query_leaf == PAL_QUERY_LEAF);
    end
  end

  // Lookup pipeline, one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lookup_done_r <= 1'b0;
      table_type_r <= 3'h0;
      effective_type_r <= 3'h0;
    end else begin
      lookup_done_r <= lookup_valid;
      if (lookup_valid) begin
        table_type_r <= sel_type;
        effective_type_r <= eff_type;
      end
    end
  end

  // Assertions
  property p_bad_write_faults;
    @(posedge clk) disable iff (!rst_n)
      (reg_write && !soft_init && hit && priv_ok && wr_bad) |=>
        protection_fault_r && reg_done_r;
  endproperty
  a_bad_write_faults: assert property (p_bad_write_faults)
    else $error("illegal write did not fault");

  property p_bad_write_keeps;
    @(posedge clk) disable iff (!rst_n)
      (reg_write && (wr_bad || !priv_ok || !hit)) |=>
        page_attribute_table_r == $past(page_attribute_table_r);
  endproperty
  a_bad_write_keeps: assert property (p_bad_write_keeps)
    else $error("rejected write changed table");

  property p_priv_fault;
    @(posedge clk) disable iff (!rst_n)
      ((reg_read || reg_write) && !soft_init && !priv_ok) |=>
        protection_fault_r;
  endproperty
  a_priv_fault: assert property (p_priv_fault)
    else $error("unprivileged access did not fault");

  property p_good_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_write && hit && priv_ok && !wr_bad && !soft_init) |=>
        page_attribute_table_r == $past(reg_wdata) && !protection_fault_r;
  endproperty
  a_good_write: assert property (p_good_write)
    else $error("legal write not stored");

  property p_lookup_sel;
    @(posedge clk) disable iff (!rst_n)
      lookup_valid |=> lookup_done_r && table_type_r == $past(sel_type);
  endproperty
  a_lookup_sel: assert property (p_lookup_sel)
    else $error("lookup selected wrong entry");

  property p_reset_table;
    @(posedge clk) !rst_n |=> page_attribute_table_r == PAL_TABLE_RESET;
  endproperty
  a_reset_table: assert property (p_reset_table)
    else $error("table not at reset image");

  property p_soft_keep;
    @(posedge clk) disable iff (!rst_n)
      soft_init |=> $stable(page_attribute_table_r);
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("soft init changed table");

  property p_query;
    @(posedge clk) disable iff (!rst_n)
      (query_valid && query_leaf == 32'h1) |=> query_result_r[16];
  endproperty
  a_query: assert property (p_query)
    else $error("feature flag missing");

  property p_query_other;
    @(posedge clk) disable iff (!rst_n)
      (query_valid && query_leaf != PAL_QUERY_LEAF) |=>
        query_result_r == 32'h0;
  endproperty
  a_query_other: assert property (p_query_other)
    else $error("feature flag set for other leaf");

  property p_soft_quiet;
    @(posedge clk) disable iff (!rst_n)
      soft_init |=> !reg_done_r && !protection_fault_r;
  endproperty
  a_soft_quiet: assert property (p_soft_quiet)
    else $error("access answered during soft init");

  property p_uc_range;
    @(posedge clk) disable iff (!rst_n)
      (lookup_valid && range_type == 3'h0) |=> effective_type_r == 3'h0;
  endproperty
  a_uc_range: assert property (p_uc_range)
    else $error("uncacheable range not honoured");
endmodule // pal_lookup
`default_nettype wire

// >>> pal_pager.sv
// Purpose: Paging-unit model presenting page entries for lookup
// Assumes: One lookup at a time, launched just after a rising edge
// Notes: Idle entry is the inverse of the last one, never stale bits
`timescale 1ns/100ps
`default_nettype none
module pal_pager import pal_pkg::*; (
  input wire logic clk,
  output logic lookup_valid,
  output logic large_page,
  output logic [63:0] page_entry,
  output logic [2:0] range_type
);
  initial {lookup_valid, large_page, page_entry, range_type} = 69'h0;
  task automatic send(logic [2:0] i, logic lg, logic [2:0] rt);
    logic [63:0] e;
    // Unused attribute position gets the opposite bit to expose a mix-up
    e = {51'h7_FFFF_FFFF_FFFF, i[2] ^ ~lg, 4'hF, i[2] ^ lg, 2'h3, i[1:0],
         3'h7};
    @(posedge clk) {lookup_valid, large_page, page_entry, range_type} <=
                   {1'b1, lg, e, rt};
    @(posedge clk) {lookup_valid, page_entry} <= {1'b0, ~e};
  endtask
endmodule // pal_pager
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the page attribute lookup
// Assumes: Stimulus by non-blocking assignment at rising edges
// Notes: Expected values are worked out from the type encodings
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pal_pkg::*;
  localparam logic [31:0] TA = PAL_TABLE_ADDR;
  localparam logic [63:0] RST_IMG = 64'h0007_0406_0007_0406;
  logic clk = 1'b0, rst_n = 1'b0, soft_init = 1'b0, query_valid = 1'b0;
  logic reg_read = 1'b0, reg_write = 1'b0, reg_done_r, protection_fault_r;
  logic [31:0] query_leaf = '0, reg_addr = '0, query_result_r;
  logic [63:0] reg_wdata = '0, reg_rdata_r, page_entry, w;
  logic [1:0] privilege_level = '0;
  logic lookup_valid, large_page, lookup_done_r;
  logic [2:0] range_type, table_type_r, effective_type_r, t, rt;
  int errors = 0, checked = 0, cycles = 0;
  pal_pager pager (
    .clk(clk),
    .lookup_valid(lookup_valid),
    .large_page(large_page),
    .page_entry(page_entry),
    .range_type(range_type)
  );
  pal_lookup uut (
    .clk(clk),
    .rst_n(rst_n),
    .soft_init(soft_init),
    .query_valid(query_valid),
    .query_leaf(query_leaf),
    .query_result_r(query_result_r),
    .reg_read(reg_read),
    .reg_write(reg_write),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .privilege_level(privilege_level),
    .reg_rdata_r(reg_rdata_r),
    .reg_done_r(reg_done_r),
    .protection_fault_r(protection_fault_r),
    .lookup_valid(lookup_valid),
    .large_page(large_page),
    .page_entry(page_entry),
    .range_type(range_type),
    .lookup_done_r(lookup_done_r),
    .table_type_r(table_type_r),
    .effective_type_r(effective_type_r)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cycles == 3000) results(1);
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    checked++;
    if (g !== e) $display("MISMATCH %s exp %h got %h", n, e, g);
    if (g !== e) errors++;
  endtask
  task automatic results(int to);
    errors += to;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // No answer at all is due while soft init is held
  task automatic acc(logic r, logic wr, logic [31:0] a, logic [63:0] d,
                     logic [1:0] p, logic f);
    @(posedge clk) {reg_read, reg_write, reg_addr, reg_wdata,
                    privilege_level} <= {r, wr, a, d, p};
    @(posedge clk) {reg_read, reg_write} <= 2'h0;
    #1 chk("done", 64'(!soft_init), 64'(reg_done_r));
    chk("fault", 64'(f), 64'(protection_fault_r));
    chk("rdata", (r && !f && !soft_init) ? w : '0, reg_rdata_r);
  endtask
  task automatic t_reset();
    w = RST_IMG;
    acc('1, '0, TA, '0, '0, '0);
    @(posedge clk) {query_valid, query_leaf} <= {1'b1, PAL_QUERY_LEAF};
    @(posedge clk) query_valid <= 1'b0;
    #1 chk("query", 64'h1 << PAL_QUERY_BIT, 64'(query_result_r));
    @(posedge clk) {query_valid, query_leaf} <= {1'b1, 32'h2};
    @(posedge clk) query_valid <= 1'b0;
    #1 chk("query2", 64'h0, 64'(query_result_r));
    // Legacy index values must land on the old direct types
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? PAL_WRITE_BACK : (i == 1) ? PAL_WRITE_THROUGH_TYPE :
          (i == 2) ? PAL_WEAK_UNCACHEABLE : PAL_UNCACHEABLE;
      pager.send(3'(i), 1'b0, PAL_WRITE_BACK);
      #1 chk("legacy", 64'(t), 64'(table_type_r));
    end
    $display("reset test done");
  endtask
  task automatic t_table();
    w = 64'h0106_0704_0600_0501;
    acc('0, '1, TA, w, '0, '0);
    acc('1, '0, TA, '0, '0, '0);
    // Each range type in turn: back, back, combining, through, uncached
    for (int i = 0; i < 40; i++) begin
      t = w[8 * (i % 8) +: 3];
      rt = (i < 16) ? 3'h6 : (i < 24) ? 3'h1 : (i < 32) ? 3'h4 : 3'h0;
      pager.send(3'(i), i[3], rt);
      #1 chk("ldone", 64'h1, 64'(lookup_done_r));
      chk("type", 64'(t), 64'(table_type_r));
      if (rt == 3'h0) t = 3'h0;
      else if (rt == 3'h1) t = (t == 3'h6) ? 3'h1 : t;
      else if (rt == 3'h4 && t == 3'h6) t = 3'h4;
      else if (t == 3'h7) t = 3'h0;
      chk("eff", 64'(t), 64'(effective_type_r));
    end
    $display("table test done");
  endtask
  task automatic t_guard();
    acc('0, '1, TA, w ^ 64'h2_0000, '0, '1);
    acc('0, '1, TA, w ^ 64'h2, '0, '1);
    acc('0, '1, TA, w | 64'h8000_0000_0000_0000, '0, '1);
    acc('1, '1, TA, RST_IMG, 2'h3, '1);
    acc('1, '0, TA + 32'h1, '0, '0, '1);
    @(posedge clk) soft_init <= 1'b1;
    acc('0, '1, TA, RST_IMG, '0, '0);
    @(posedge clk) soft_init <= 1'b0;
    acc('1, '0, TA, '0, '0, '0);
    $display("guard test done");
  endtask
  // Hard reset in mid-run must drop the written table again
  task automatic t_hard();
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("rtype", 64'h0, 64'(table_type_r));
    w = RST_IMG;
    acc('1, '0, TA, '0, '0, '0);
    $display("hard reset test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_table();
    t_guard();
    t_hard();
    results(0);
  end
endmodule // tb_top
`default_nettype wire
